// ===== hw/oms_defs.svh
// operating mode sequencer constants: timing figures and derived cycle counts
// assumes a 10 MHz core clock; times in ns, counts rounded down (longest times)
`ifndef OMS_DEFS_SVH
`define OMS_DEFS_SVH
`define OMS_CLK_NS          100
`define OMS_T_RST_NOLS_NS   1500000
`define OMS_T_RST_RO_NS     7000000
`define OMS_T_RST_XO_NS     94000000
`define OMS_T_STBY_NOLS_NS  420000
`define OMS_T_STBY_RO_NS    6200000
`define OMS_T_STBY_XO_NS    93000000
`define OMS_T_SLP_NS        420000
`define OMS_T_ARX_CH_NS     125000
`define OMS_T_ARX_NS        61000
`define OMS_T_ATX_CH_NS     131000
`define OMS_T_ATX_NS        67000
`define OMS_T_TURN_NS       150000
`define OMS_CYC(t)          ((t) / `OMS_CLK_NS)
`define OMS_SEQ_LAT         4
`define OMS_CNT_W           20
`define OMS_PWR_W           5
`define OMS_PWR_MIN         5'h00
`define OMS_PWR_MAX         5'h1a
`define OMS_LINK_DIV        4
`define OMS_DIV_W           3
`define OMS_CMD_W           8
`define OMS_CMD_FW          8'ha5
`define OMS_CMD_WAKE        8'h01
`endif

// ===== hw/oms_device.sv
// device end: operating mode sequencer with serial slave command port
// assumes link pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "oms_defs.svh"
// Overview of operation
// - reset pin forces reset from anywhere
// - reset state powers everything down, clears registers
// - reset release boots straight to active
// - reset-to-active within 1.5/7/94 ms budget
// - sleep: one low-speed oscillator, retention kept
// - second memory bank off in sleep optionally
// - sleep wake timer expiry goes active
// - host serial activity wakes from sleep
// - sleep-to-active within 0.42 ms
// - standby: no low-speed clock, host wake only
// - standby-to-active within 0.42/6.2/93 ms
// - active: core, high-speed oscillator on; radio off
// - radio states: synthesizer plus one chain
// - active-to-receive within 125 or 61 us
// - active-to-transmit within 131 or 67 us
// - receive/transmit turnaround within 150 us
// - transmit power programmable -18 to +8 dBm
// - serial slave link, host clock max 8 MHz
// - firmware reprogram command over serial link
// - serial pins high impedance in low power
// - interrupt output flags data waiting
module oms_device (
	input  wire logic                   ref_clk,
	input  wire logic                   srst,
	oms_link_if.dev                     link,
	input  wire logic                   ls_present,
	input  wire logic                   ls_is_xo,
	input  wire logic                   req_sleep,
	input  wire logic                   req_standby,
	input  wire logic                   bank2_off_sel,
	input  wire logic [`OMS_CNT_W-1:0] sleep_ticks,
	input  wire logic                   req_rx,
	input  wire logic                   req_tx,
	input  wire logic                   radio_done,
	input  wire logic                   chan_change,
	input  wire logic [`OMS_PWR_W-1:0] tx_power,
	input  wire logic                   tx_data_pending,
	output logic [6:0]                  state,
	output logic                        ldo_on,
	output logic                        ls_ro_on,
	output logic                        ls_xo_on,
	output logic                        hs_osc_on,
	output logic                        core_on,
	output logic                        bank2_on,
	output logic                        synth_on,
	output logic                        rx_chain_on,
	output logic                        tx_chain_on,
	output logic [`OMS_PWR_W-1:0]      power_amplifier,
	output logic                        fw_update,
	output logic                        settled
);
	oms_pkg::oms_state_t st_q, st_d;
	logic [2:0] cs_sync_q, clk_sync_q, mosi_sync_q;
	logic [`OMS_CMD_W-1:0] sh_q;
	logic [2:0] bit_q;
	logic miso_q, miso_oe_q, irq_q, irq_oe_q, fw_q, settled_q;
	logic ldo_q, ro_q, xo_q, hs_q, core_q, b2_q, syn_q, rxc_q, txc_q;
	logic [`OMS_PWR_W-1:0] pa_q;
	logic t_load;
	logic [`OMS_CNT_W-1:0] t_val;
	logic t_done, w_done, w_load;
	logic pend_rx_q, pend_tx_q;

	// stage 0 feeds stage 1 only; edges are found on stages 1 and 2
	always_ff @(posedge ref_clk) begin
		cs_sync_q   <= {cs_sync_q[1:0], link.chip_select_n};
		clk_sync_q  <= {clk_sync_q[1:0], link.sclk};
		mosi_sync_q <= {mosi_sync_q[1:0], link.mosi};
	end
	wire cs_act   = !cs_sync_q[1];
	wire host_act = !cs_sync_q[1] && cs_sync_q[2];
	wire sclk_re  = clk_sync_q[1] && !clk_sync_q[2] && cs_act;
	wire byte_end = sclk_re && (bit_q == 3'h7);
	wire [`OMS_CMD_W-1:0] rx_byte = {sh_q[`OMS_CMD_W-2:0], mosi_sync_q[1]};
	wire low_pwr  = (st_d == oms_pkg::OMS_SLEEP) || (st_d == oms_pkg::OMS_STANDBY) ||
		(st_d == oms_pkg::OMS_RESET);

	// budgets are the documented maxima, crystal ones divided by 256; wake occurs when a boot or wake budget runs out, radio entry does not wait
	wire [`OMS_CNT_W-1:0] boot_cyc = !ls_present ? `OMS_CNT_W'(`OMS_CYC(`OMS_T_RST_NOLS_NS)) :
		ls_is_xo ? `OMS_CNT_W'(`OMS_CYC(`OMS_T_RST_XO_NS) >> 8) :
		`OMS_CNT_W'(`OMS_CYC(`OMS_T_RST_RO_NS));
	wire [`OMS_CNT_W-1:0] stby_cyc = !ls_present ? `OMS_CNT_W'(`OMS_CYC(`OMS_T_STBY_NOLS_NS)) :
		ls_is_xo ? `OMS_CNT_W'(`OMS_CYC(`OMS_T_STBY_XO_NS) >> 8) :
		`OMS_CNT_W'(`OMS_CYC(`OMS_T_STBY_RO_NS));
	wire [`OMS_CNT_W-1:0] rx_cyc = chan_change ? `OMS_CNT_W'(`OMS_CYC(`OMS_T_ARX_CH_NS)) :
		`OMS_CNT_W'(`OMS_CYC(`OMS_T_ARX_NS));
	wire [`OMS_CNT_W-1:0] tx_cyc = chan_change ? `OMS_CNT_W'(`OMS_CYC(`OMS_T_ATX_CH_NS)) :
		`OMS_CNT_W'(`OMS_CYC(`OMS_T_ATX_NS));

	// trimmed so pin sync plus state entry and exit still land inside the budget
	wire [`OMS_CNT_W-1:0] t_val_trim = t_val - `OMS_CNT_W'(`OMS_SEQ_LAT);

	oms_timer u_budget (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.load     (t_load),
		.load_val (t_val_trim),
		.done     (t_done)
	);
	oms_timer u_wake (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.load     (w_load),
		.load_val (sleep_ticks),
		.done     (w_done)
	);

	wire go_rx = req_rx && (st_q == oms_pkg::OMS_ACTIVE || st_q == oms_pkg::OMS_TX);
	wire go_tx = req_tx && (st_q == oms_pkg::OMS_ACTIVE || st_q == oms_pkg::OMS_RX);
	assign w_load = (st_q == oms_pkg::OMS_ACTIVE) && req_sleep && !req_standby;

	// boot and wake share the budget timer; settled marks resource-ready
	always_comb begin
		st_d   = st_q;
		t_load = 1'b0;
		t_val  = boot_cyc;
		case (st_q)
			oms_pkg::OMS_RESET: begin
				st_d   = oms_pkg::OMS_BOOT;
				t_load = 1'b1;
			end
			oms_pkg::OMS_BOOT: begin
				if (t_done && settled_q) begin
					st_d = oms_pkg::OMS_ACTIVE;
				end
			end
			oms_pkg::OMS_STANDBY: begin
				if (host_act) begin
					st_d   = oms_pkg::OMS_BOOT;
					t_load = 1'b1;
					t_val  = stby_cyc;
				end
			end
			oms_pkg::OMS_SLEEP: begin
				if (w_done || host_act) begin
					st_d   = oms_pkg::OMS_BOOT;
					t_load = 1'b1;
					t_val  = `OMS_CNT_W'(`OMS_CYC(`OMS_T_SLP_NS));
				end
			end
			oms_pkg::OMS_ACTIVE: begin
				if (req_standby) begin
					st_d = oms_pkg::OMS_STANDBY;
				end else if (req_sleep) begin
					st_d = ls_present ? oms_pkg::OMS_SLEEP : oms_pkg::OMS_STANDBY;
				end else if (go_rx || go_tx) begin
					st_d   = go_tx ? oms_pkg::OMS_TX : oms_pkg::OMS_RX;
					t_load = 1'b1;
					t_val  = go_tx ? tx_cyc : rx_cyc;
				end
			end
			oms_pkg::OMS_RX, oms_pkg::OMS_TX: begin
				if (radio_done) begin
					st_d = oms_pkg::OMS_ACTIVE;
				end else if ((st_q == oms_pkg::OMS_RX) ? go_tx : go_rx) begin
					st_d   = (st_q == oms_pkg::OMS_RX) ? oms_pkg::OMS_TX : oms_pkg::OMS_RX;
					t_load = 1'b1;
					t_val  = `OMS_CNT_W'(`OMS_CYC(`OMS_T_TURN_NS));
				end
			end
			default: begin
				st_d = oms_pkg::OMS_RESET;
			end
		endcase
	end

	wire in_radio = (st_d == oms_pkg::OMS_RX) || (st_d == oms_pkg::OMS_TX);
	wire running  = (st_d == oms_pkg::OMS_ACTIVE) || in_radio || (st_d == oms_pkg::OMS_BOOT);
	wire [`OMS_PWR_W-1:0] pa_clip = (tx_power > `OMS_PWR_MAX) ? `OMS_PWR_MAX : tx_power;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q      <= oms_pkg::OMS_RESET;
			{ldo_q, ro_q, xo_q, hs_q, core_q, b2_q, syn_q, rxc_q, txc_q} <= '0;
			pa_q      <= `OMS_PWR_MIN;
			sh_q      <= '0;
			bit_q     <= '0;
			{miso_q, miso_oe_q, irq_q, irq_oe_q, fw_q, settled_q} <= '0;
		end else begin
			st_q      <= st_d;
			settled_q <= (st_d == oms_pkg::OMS_BOOT) ? 1'b1 : settled_q && running;
			ldo_q     <= (st_d != oms_pkg::OMS_RESET);
			hs_q      <= running;
			core_q    <= running;
			ro_q      <= ls_present && !ls_is_xo && (st_d != oms_pkg::OMS_STANDBY);
			xo_q      <= ls_present && ls_is_xo && (st_d != oms_pkg::OMS_STANDBY);
			b2_q      <= !(low_pwr && bank2_off_sel) && (st_d != oms_pkg::OMS_RESET);
			syn_q     <= in_radio;
			rxc_q     <= (st_d == oms_pkg::OMS_RX);
			txc_q     <= (st_d == oms_pkg::OMS_TX);
			pa_q      <= (st_d == oms_pkg::OMS_TX) ? pa_clip : pa_q;
			if (!cs_act) begin
				bit_q <= '0;
			end else if (sclk_re) begin
				bit_q <= bit_q + 3'h1;
				sh_q  <= rx_byte;
			end
			if (byte_end && rx_byte == `OMS_CMD_FW && running) begin
				fw_q <= 1'b1;
			end
			miso_q    <= tx_data_pending;
			miso_oe_q <= cs_act && !low_pwr;
			irq_q     <= tx_data_pending && !low_pwr;
			irq_oe_q  <= !low_pwr;
		end
	end

	assign state           = st_q;
	assign ldo_on          = ldo_q;
	assign ls_ro_on        = ro_q;
	assign ls_xo_on        = xo_q;
	assign hs_osc_on       = hs_q;
	assign core_on         = core_q;
	assign bank2_on        = b2_q;
	assign synth_on        = syn_q;
	assign rx_chain_on     = rxc_q;
	assign tx_chain_on     = txc_q;
	assign power_amplifier = pa_q;
	assign fw_update       = fw_q;
	assign settled         = settled_q;
	assign link.miso       = miso_q;
	assign link.miso_oe    = miso_oe_q;
	assign link.irq        = irq_q;
	assign link.irq_oe     = irq_oe_q;
endmodule
`default_nettype wire

// ===== hw/oms_host.sv
// host end: serial master sending one command byte per request
// assumes irq comes from the device's pins, so it is synchronised; miso is not used
`timescale 1ns/1ps
`default_nettype none
`include "oms_defs.svh"
module oms_host (
	input  wire logic                   ref_clk,
	input  wire logic                   srst,
	oms_link_if.host                    link,
	input  wire logic                   send,
	input  wire logic [`OMS_CMD_W-1:0] cmd,
	output logic                        busy,
	output logic                        irq_seen
);
	logic [`OMS_DIV_W-1:0] div_q;
	logic [`OMS_CMD_W-1:0] sh_q;
	logic [3:0] bits_q;
	logic cs_n_q, sclk_q, mosi_q, busy_q;
	logic [1:0] irq_sync_q;
	logic irq_q;
	// divider by 4 from 10 MHz keeps the link well under 8 MHz
	wire tick = (div_q == `OMS_DIV_W'(`OMS_LINK_DIV / 2 - 1));
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			div_q  <= '0;
			sh_q   <= '0;
			bits_q <= '0;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
			busy_q <= 1'b0;
			irq_sync_q <= '0;
			irq_q  <= 1'b0;
		end else begin
			irq_sync_q <= {irq_sync_q[0], link.irq && link.irq_oe};
			irq_q      <= irq_sync_q[1];
			div_q      <= tick ? '0 : div_q + `OMS_DIV_W'(1);
			if (!busy_q && send) begin
				busy_q <= 1'b1;
				cs_n_q <= 1'b0;
				sh_q   <= cmd;
				bits_q <= 4'h0;
				mosi_q <= cmd[`OMS_CMD_W-1];
			end else if (busy_q && tick) begin
				if (!sclk_q && bits_q == 4'h8) begin
					busy_q <= 1'b0;
					cs_n_q <= 1'b1;
				end else if (!sclk_q) begin
					sclk_q <= 1'b1;
					bits_q <= bits_q + 4'h1;
				end else begin
					sclk_q <= 1'b0;
					sh_q   <= {sh_q[`OMS_CMD_W-2:0], 1'b0};
					mosi_q <= sh_q[`OMS_CMD_W-2];
				end
			end
		end
	end
	assign link.chip_select_n = cs_n_q;
	assign link.sclk          = sclk_q;
	assign link.mosi          = mosi_q;
	assign busy               = busy_q;
	assign irq_seen           = irq_q;
endmodule
`default_nettype wire

// ===== hw/oms_link_if.sv
// host command link: serial slave pins plus data-ready interrupt
// miso is driven at all times and miso_oe tells whether the pin would drive; nothing resolves the wire
`timescale 1ns/1ps
`default_nettype none
interface oms_link_if;
	logic chip_select_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic irq;
	logic irq_oe;
	modport dev (input chip_select_n, input sclk, input mosi, output miso, output miso_oe,
		output irq, output irq_oe);
	modport host (output chip_select_n, output sclk, output mosi, input miso, input miso_oe,
		input irq, input irq_oe);
endinterface
`default_nettype wire

// ===== hw/oms_pkg.sv
// operating mode sequencer types used by the device end
package oms_pkg;
	typedef enum logic [6:0] {
		OMS_RESET   = 7'h01,
		OMS_BOOT    = 7'h02,
		OMS_STANDBY = 7'h04,
		OMS_SLEEP   = 7'h08,
		OMS_ACTIVE  = 7'h10,
		OMS_RX      = 7'h20,
		OMS_TX      = 7'h40
	} oms_state_t;
	typedef enum logic [1:0] {
		OMS_LS_NONE = 2'h0,
		OMS_LS_RO   = 2'h1,
		OMS_LS_XO   = 2'h2
	} oms_ls_t;
endpackage

// ===== hw/oms_timer.sv
// down-counter used for transition budgets and the sleep wake timer
// assumes load comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "oms_defs.svh"
module oms_timer (
	input  wire logic                   ref_clk,
	input  wire logic                   srst,
	input  wire logic                   load,
	input  wire logic [`OMS_CNT_W-1:0] load_val,
	output logic                        done
);
	logic [`OMS_CNT_W-1:0] cnt_q;
	always_ff @(posedge ref_clk) begin
		if (srst || load) begin
			cnt_q <= srst ? '0 : load_val;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - `OMS_CNT_W'(1);
		end
	end
	assign done = (cnt_q == '0) && !load;
endmodule
`default_nettype wire

// ===== test/oms_properties.sv
// assertion checker for link pins and power outputs of the mode sequencer
// assumes one clock domain; the bench instantiates it beside the link
`timescale 1ns/1ps
`default_nettype none
module oms_properties (
	input wire logic       ref_clk,
	input wire logic       srst,
	input wire logic       sclk,
	input wire logic       miso_oe,
	input wire logic       irq_oe,
	input wire logic       ls_present,
	input wire logic [6:0] state,
	input wire logic       ldo_on,
	input wire logic       ls_ro_on,
	input wire logic       ls_xo_on,
	input wire logic       hs_osc_on,
	input wire logic       core_on,
	input wire logic       synth_on,
	input wire logic       rx_chain_on,
	input wire logic       tx_chain_on
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic [13:0] boot_q;
	wire logic   in_boot = state == 7'h02;
	wire logic   radio   = state == 7'h20 || state == 7'h40;
	wire logic   low_pwr = state == 7'h08 || state == 7'h04;
	// saturates well past the limit, so a stuck boot still trips
	always_ff @(posedge ref_clk)
		boot_q <= (srst || !in_boot) ? 14'h0000 : boot_q + {13'h0000, ~&boot_q};
	sequence entered_radio;
		$rose(radio);
	endsequence
	sequence came_from_active;
		$past(state) == 7'h10 || $past(radio);
	endsequence
	chk_reset_state: assert property (
		$fell(srst) |-> state == 7'h01 && !ldo_on && !hs_osc_on && !ls_ro_on)
		else $error("state not powered down in reset");
	chk_reset_boot: assert property (
		$fell(srst) |=> state == 7'h02)
		else $error("no boot after reset release");
	chk_boot_budget: assert property (
		in_boot && !ls_present |-> boot_q <= 14'h3a98)
		else $error("boot longer than budget");
	chk_active_res: assert property (
		state == 7'h10 |-> ldo_on && hs_osc_on && core_on && !synth_on && !rx_chain_on && !tx_chain_on)
		else $error("active resources wrong");
	chk_radio_res: assert property (
		radio |-> synth_on && core_on && rx_chain_on == (state == 7'h20) && tx_chain_on == (state == 7'h40))
		else $error("radio resources wrong");
	chk_sleep_osc: assert property (
		state == 7'h08 |-> (ls_ro_on ^ ls_xo_on) && !hs_osc_on && !core_on && ldo_on)
		else $error("sleep resources wrong");
	chk_standby_osc: assert property (
		state == 7'h04 |-> !ls_ro_on && !ls_xo_on && !hs_osc_on && ldo_on)
		else $error("standby resources wrong");
	chk_radio_entry: assert property (
		entered_radio |-> came_from_active)
		else $error("radio entered from low power");
	chk_lowpwr_hiz: assert property (
		low_pwr [*2] |-> !miso_oe && !irq_oe)
		else $error("link pins driven in low power");
	chk_link_rate: assert property (
		$changed(sclk) |=> $stable(sclk))
		else $error("link clock too fast");
endmodule
`default_nettype wire

// ===== test/operating_mode_sequencer_tb.sv
// self-checking bench: device and host ends joined by one link
// assumes budgets in oms_defs.svh; outputs sampled 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
`include "oms_defs.svh"
module operating_mode_sequencer_tb;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic        ls_present = 1'b0, ls_is_xo = 1'b0, req_sleep = 1'b0, req_standby = 1'b0;
	logic        bank2_off_sel = 1'b0, req_rx = 1'b0, req_tx = 1'b0, radio_done = 1'b0;
	logic        chan_change = 1'b0, tx_data_pending = 1'b0, send = 1'b0;
	logic [19:0] sleep_ticks = 20'h00064;
	logic [4:0]  tx_power = 5'h00;
	logic [7:0]  cmd = 8'h00;
	logic [6:0]  state;
	logic        ldo_on, ls_ro_on, ls_xo_on, hs_osc_on, core_on, bank2_on, synth_on;
	logic        rx_chain_on, tx_chain_on, fw_update, busy, irq_seen, settled;
	logic [4:0]  power_amplifier;
	int          fail_count = 0, num_checks = 0, i, bud;
	// rows: {req_rx, req_tx, chan_change, expected state}
	logic [9:0]  rows [5] = '{{3'b100, 7'h20}, {3'b101, 7'h20}, {3'b010, 7'h40}, {3'b011, 7'h40},
		{3'b110, 7'h40}};
	oms_link_if oms_link_if_i ();
	oms_device oms_device_i (.ref_clk, .srst, .link(oms_link_if_i.dev), .ls_present, .ls_is_xo, .req_sleep,
		.req_standby, .bank2_off_sel, .sleep_ticks, .req_rx, .req_tx, .radio_done, .chan_change, .tx_power,
		.tx_data_pending, .state, .ldo_on, .ls_ro_on, .ls_xo_on, .hs_osc_on, .core_on, .bank2_on, .synth_on,
		.rx_chain_on, .tx_chain_on, .power_amplifier, .fw_update, .settled);
	oms_host oms_host_i (.ref_clk, .srst, .link(oms_link_if_i.host), .send, .cmd, .busy, .irq_seen);
	oms_properties oms_properties_i (.ref_clk, .srst, .sclk(oms_link_if_i.sclk),
		.miso_oe(oms_link_if_i.miso_oe), .irq_oe(oms_link_if_i.irq_oe), .ls_present, .state, .ldo_on,
		.ls_ro_on, .ls_xo_on, .hs_osc_on, .core_on, .synth_on, .rx_chain_on, .tx_chain_on);
	always #50 ref_clk = ~ref_clk;
	task automatic chk_bit(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic chk_val(input string n, input logic [6:0] e, input logic [6:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// bounded: a state never reached ends the run
	task automatic wait_st(input logic [6:0] s, input int n);
		for (int k = 0; k < n && state !== s; k++) begin
			@(posedge ref_clk);
			#1;
		end
		chk_val("state", s, state);
		if (state !== s)
			stop_test();
	endtask
	task automatic wait_hi(ref logic b, input int n);
		for (int k = 0; k < n && b !== 1'b1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		if (b !== 1'b1) begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic host_cmd(input logic [7:0] c);
		@(posedge ref_clk);
		cmd <= c;
		send <= 1'b1;
		wait_hi(busy, 8);
		@(posedge ref_clk);
		send <= 1'b0;
		for (int k = 0; k < 80 && busy !== 1'b0; k++) begin
			@(posedge ref_clk);
			#1;
		end
		chk_bit("busy", 1'b0, busy);
		if (busy !== 1'b0)
			stop_test();
	endtask
	initial begin
		repeat (7) @(posedge ref_clk);
		#1;
		chk_val("state", 7'h01, state);
		chk_bit("ldo_on", 1'b0, ldo_on);
		chk_bit("settled", 1'b0, settled);
		chk_bit("miso_oe", 1'b0, oms_link_if_i.miso_oe);
		@(posedge ref_clk);
		srst <= 1'b0;
		wait_st(7'h10, `OMS_CYC(`OMS_T_RST_NOLS_NS));
		chk_bit("settled", 1'b1, settled);
		chk_bit("fw_update", 1'b0, fw_update);
		host_cmd(`OMS_CMD_FW);
		wait_hi(fw_update, 20);
		chk_bit("fw_update", 1'b1, fw_update);
		@(posedge ref_clk);
		tx_data_pending <= 1'b1;
		wait_hi(irq_seen, 20);
		chk_bit("irq_seen", 1'b1, irq_seen);
		@(posedge ref_clk);
		tx_data_pending <= 1'b0;
		for (i = 0; i < 5; i++) begin
			@(posedge ref_clk);
			{req_rx, req_tx, chan_change} <= rows[i][9:7];
			tx_power <= 5'(i * 6);
			bud = rows[i][8] ? (rows[i][7] ? `OMS_CYC(`OMS_T_ATX_CH_NS) : `OMS_CYC(`OMS_T_ATX_NS))
				: (rows[i][7] ? `OMS_CYC(`OMS_T_ARX_CH_NS) : `OMS_CYC(`OMS_T_ARX_NS));
			wait_st(rows[i][6:0], bud);
			chk_bit("rx_chain_on", !rows[i][8], rx_chain_on);
			chk_bit("synth_on", 1'b1, synth_on);
			if (rows[i][8])
				chk_val("power_amplifier", 7'(i * 6), {2'h0, power_amplifier});
			@(posedge ref_clk);
			{req_rx, req_tx, radio_done} <= 3'b001;
			wait_st(7'h10, 8);
			chk_bit("synth_on", 1'b0, synth_on);
			@(posedge ref_clk);
			radio_done <= 1'b0;
		end
		req_rx <= 1'b1;
		tx_power <= 5'h1f;
		wait_st(7'h20, `OMS_CYC(`OMS_T_ARX_NS) + 4);
		@(posedge ref_clk);
		{req_rx, req_tx} <= 2'b01;
		wait_st(7'h40, `OMS_CYC(`OMS_T_TURN_NS));
		chk_val("power_amplifier", {2'h0, `OMS_PWR_MAX}, {2'h0, power_amplifier});
		@(posedge ref_clk);
		{srst, ls_present, ls_is_xo, req_tx} <= 4'b1110;
		repeat (2) @(posedge ref_clk);
		#1;
		chk_val("state", 7'h01, state);
		chk_bit("tx_chain_on", 1'b0, tx_chain_on);
		chk_bit("fw_update", 1'b0, fw_update);
		@(posedge ref_clk);
		srst <= 1'b0;
		wait_st(7'h10, `OMS_CYC(`OMS_T_RST_XO_NS) >> 8);
		for (i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			{ls_is_xo, bank2_off_sel, req_sleep} <= {!i[0], !i[0], 1'b1};
			sleep_ticks <= i[0] ? 20'hfffff : 20'h00064;
			wait_st(7'h08, 8);
			@(posedge ref_clk);
			req_sleep <= 1'b0;
			chk_bit("ls_xo_on", !i[0], ls_xo_on);
			chk_bit("bank2_on", i[0], bank2_on);
			chk_bit("miso_oe", 1'b0, oms_link_if_i.miso_oe);
			if (i[0])
				host_cmd(`OMS_CMD_WAKE);
			wait_st(7'h10, 100 + `OMS_CYC(`OMS_T_SLP_NS) + 8);
		end
		// case 0: sleep asked with no low-speed source falls back to standby
		for (i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			{ls_present, ls_is_xo, req_sleep, req_standby} <= {i[0], 1'b1, !i[0], i[0]};
			sleep_ticks <= 20'h00010;
			wait_st(7'h04, 8);
			@(posedge ref_clk);
			{req_sleep, req_standby, req_rx} <= 3'b001;
			repeat (300) @(posedge ref_clk);
			chk_val("state", 7'h04, state);
			chk_bit("ls_xo_on", 1'b0, ls_xo_on);
			req_rx <= 1'b0;
			host_cmd(`OMS_CMD_WAKE);
			wait_st(7'h10, i[0] ? (`OMS_CYC(`OMS_T_STBY_XO_NS) >> 8) : `OMS_CYC(`OMS_T_STBY_NOLS_NS));
		end
		stop_test();
	end
endmodule
`default_nettype wire
